// ---- common/bmc_pkg.sv ----
// Purpose: shared constants, types and carriers of the battery monitor and
//          charger control block
// Assumes: 25 MHz reference clock
// Notes:   analog levels are codes; level = base + code * step
package bmc_pkg;

	// clock and derived timing counts
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
	localparam int unsigned DOCK_DEB_US = 100_000; // dock debounce, 100 ms
	// strictly longer than the debounce time, hence the extra cycle
	localparam int unsigned DOCK_DEB_CYC = DOCK_DEB_US * CLK_PER_US + 1;
	localparam int unsigned REL_TO_US = 3_000; // release timeout, least 3.0 ms
	localparam int unsigned REL_TO_CYC = REL_TO_US * CLK_PER_US;
	localparam int unsigned SETTLE_US = 50; // settle window after a margin move
	localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_PER_US;
	localparam int unsigned MINUTE_S = 60;
	localparam int unsigned MINUTE_CYC = MINUTE_S * CLK_HZ;

	// counter widths
	localparam int unsigned DOCK_W = 22;
	localparam int unsigned REL_W = 17;
	localparam int unsigned SETTLE_W = 12;
	localparam int unsigned PRESC_W = 31;
	localparam int unsigned MIN_W = 11;

	// charge termination timer settings in minutes
	localparam logic [10:0] PRE_TMR_MIN1 = 11'h02c; // 44 min
	localparam logic [10:0] PRE_TMR_MIN2 = 11'h057; // 1 h 27 min
	localparam logic [10:0] PRE_TMR_MIN3 = 11'h0af; // 2 h 55 min
	localparam logic [10:0] FAST_TMR_MIN1 = 11'h15c; // 5 h 48 min
	localparam logic [10:0] FAST_TMR_MIN2 = 11'h2b8; // 11 h 36 min
	localparam logic [10:0] FAST_TMR_MIN3 = 11'h564; // 23 h

	// margin levels and channel groups
	localparam logic [2:0] MARGIN_NOM = 3'h0;
	localparam logic [2:0] MARGIN_HIGH = 3'h1;
	localparam logic [2:0] MARGIN_LOW = 3'h2;
	localparam logic [2:0] SEVEN_MAX = 3'h6;
	localparam logic [7:0] SEVEN_CH_MASK = 8'h30; // channels 4 and 5
	localparam logic [7:0] SEVEN_LOST_MASK = 8'hc9; // channels 0, 3, 6, 7

	// positions of the asynchronous sense inputs in the synchroniser
	localparam int unsigned SY_DOCK = 0;
	localparam int unsigned SY_PF = 1;
	localparam int unsigned SY_LOW = 2;
	localparam int unsigned SY_V2 = 3;
	localparam int unsigned SY_PREV = 4;
	localparam int unsigned SY_FLOAT = 5;
	localparam int unsigned SY_TERM = 6;
	localparam int unsigned SY_TOVER = 7;
	localparam int unsigned SY_TUNDER = 8;
	localparam int unsigned SY_PWRON = 9;
	localparam int unsigned SY_N = 10;

	// fault log bits
	localparam int unsigned FLT_PRE = 0;
	localparam int unsigned FLT_FAST = 1;

	typedef enum logic [1:0] {
		BMC_RESP_NONE = 2'b00,
		BMC_RESP_POWER_OFF = 2'b01,
		BMC_RESP_FORCE = 2'b10
	} bmc_resp_t;

	typedef enum logic [2:0] {
		BMC_CHG_IDLE = 3'b000,
		BMC_CHG_TRICKLE = 3'b001,
		BMC_CHG_PRE = 3'b010,
		BMC_CHG_FAST = 3'b011,
		BMC_CHG_TAPER = 3'b100,
		BMC_CHG_SUSP = 3'b101,
		BMC_CHG_DONE = 3'b110
	} bmc_chg_state_t;

	// threshold codes handed to the comparator DACs
	typedef struct packed {
		logic [2:0] dock_sel; // 3.4 V + code * 200 mV
		logic [2:0] pf_sel; // 2.55 V + code * 150 mV
		logic [2:0] low_sel; // 2.55 V + code * 150 mV
		logic [2:0] pre_v_sel; // 2.5 V + code * 100 mV
		logic [2:0] over_t_sel; // 30 C + code * 5 C
		logic [2:0] under_t_sel; // -20 C + code * 5 C
	} bmc_thresh_t;

	typedef struct packed {
		logic [3:0] pre_i_sel; // 25 mA + code * 15 mA
		logic [3:0] fast_i_sel; // 100 mA + code * 60 mA
		logic wait_cmd; // charge only after a start command
		logic skip_taper; // finish at float voltage
		logic [1:0] pre_tmr_sel; // 0 disables
		logic [1:0] fast_tmr_sel; // 0 disables
	} bmc_chg_cfg_t;

	typedef struct packed {
		logic valid;
		logic [2:0] ch;
		logic [2:0] level;
	} bmc_margin_wr_t;

endpackage

// ---- design/bmc_timer.sv ----
// Purpose: run-length timer; counts while run is held, clears when dropped
// Assumes: limit is stable while running
// Notes:   done stays high while run is held after the limit is reached
`timescale 1ns/1ps
module bmc_timer #(
	parameter int unsigned W = 16
) (
	input logic ref_clk_in,
	input logic rst_b_in,
	input logic run_in,
	input logic [W-1:0] limit_in,
	output logic done_out
);

	logic [W-1:0] cnt_q;

	// saturate at the limit so a held run never wraps into a false restart
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			cnt_q <= '0;
		end else if (!run_in) begin
			cnt_q <= '0;
		end else if (cnt_q != limit_in) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign done_out = run_in && (cnt_q == limit_in);

endmodule // bmc_timer

// ---- design/bmc_ctrl.sv ----
// Purpose: battery supervision, fault response, margin state and Li-ion
//          charge sequencing for a multi-channel power manager
// Assumes: analog comparators outside; their outputs are asynchronous
// Notes:   host commands are one-cycle pulses on ref_clk_in
`timescale 1ns/1ps
module bmc_ctrl #(
	parameter int unsigned DOCK_DEB_CYC = bmc_pkg::DOCK_DEB_CYC,
	parameter int unsigned REL_TO_CYC = bmc_pkg::REL_TO_CYC,
	parameter int unsigned MINUTE_CYC = bmc_pkg::MINUTE_CYC
) (
	input logic ref_clk_in,
	input logic rst_b_in,
	input logic dock_above_in,
	input logic pf_above_in,
	input logic low_above_in,
	input logic batt_above_2v_in,
	input logic batt_above_pre_in,
	input logic batt_at_float_in,
	input logic chg_below_term_in,
	input logic temp_over_in,
	input logic temp_under_in,
	input logic power_on_pin_in,
	input logic pf_clear_cmd_in,
	input logic power_on_cmd_in,
	input logic charge_start_cmd_in,
	input logic fault_log_clear_in,
	input bmc_pkg::bmc_margin_wr_t margin_wr_in,
	input bmc_pkg::bmc_thresh_t thresh_cfg_in,
	input bmc_pkg::bmc_chg_cfg_t chg_cfg_in,
	input bmc_pkg::bmc_resp_t fault_resp_in,
	input logic latch_off_en_in,
	input logic seven_level_en_in,
	input logic uvov_suppress_en_in,
	output logic dock_present_out,
	output logic power_fail_out,
	output logic battery_low_n_out,
	output logic power_off_req_out,
	output logic force_shutdown_out,
	output logic outputs_held_out,
	output bmc_pkg::bmc_thresh_t thresh_dac_out,
	output logic [23:0] margin_status_out,
	output logic [7:0] uvov_mask_out,
	output logic dvm_busy_out,
	output bmc_pkg::bmc_chg_state_t charge_state_out,
	output logic charge_en_out,
	output logic [3:0] charge_current_out,
	output logic [1:0] charge_fault_out
);

	logic [bmc_pkg::SY_N-1:0] sense_raw;
	logic [bmc_pkg::SY_N-1:0] sync1_q;
	logic [bmc_pkg::SY_N-1:0] sync2_q;
	logic pwr_prev_q;
	logic dock_s, pf_above_s, low_above_s, pwr_toggle;
	logic dock_done, pf_done, low_done, settle_done;
	logic dock_present_q, pf_q, pf_pend_q, low_q, low_rel, clear_evt;
	logic low_n_q;
	logic fault_rise, power_off_q, force_q, held_q;
	bmc_pkg::bmc_thresh_t thresh_q;
	logic [7:0][2:0] margin_q;
	logic [7:0] mask_q;
	logic wr_ok, mask_set, busy_q;
	bmc_pkg::bmc_chg_state_t state_q, state_d, resume_q;
	logic start_pend_q, temp_bad, chg_go, charge_en_q;
	logic [3:0] current_q;
	logic [1:0] fault_q;
	logic pre_run, fast_run, tick, pre_exp, fast_exp;
	logic [bmc_pkg::PRESC_W-1:0] presc_q;
	logic [bmc_pkg::MIN_W-1:0] pre_min_q, fast_min_q, pre_lim, fast_lim;

	assign sense_raw = {power_on_pin_in, temp_under_in, temp_over_in,
		chg_below_term_in, batt_at_float_in, batt_above_pre_in,
		batt_above_2v_in, low_above_in, pf_above_in, dock_above_in};

	// battery levels reset to above so a reset alone never trips a fault
	localparam logic [bmc_pkg::SY_N-1:0] SY_RST =
		bmc_pkg::SY_N'((1 << bmc_pkg::SY_PF) | (1 << bmc_pkg::SY_LOW));

	// two-flop synchroniser; power pin also keeps a history bit for toggles
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			sync1_q <= SY_RST;
			sync2_q <= SY_RST;
			pwr_prev_q <= 1'b0;
		end else begin
			sync1_q <= sense_raw;
			sync2_q <= sync1_q;
			pwr_prev_q <= sync2_q[bmc_pkg::SY_PWRON];
		end
	end

	assign dock_s = sync2_q[bmc_pkg::SY_DOCK];
	assign pf_above_s = sync2_q[bmc_pkg::SY_PF];
	assign low_above_s = sync2_q[bmc_pkg::SY_LOW];
	assign pwr_toggle = sync2_q[bmc_pkg::SY_PWRON] ^ pwr_prev_q;
	assign temp_bad = sync2_q[bmc_pkg::SY_TOVER] | sync2_q[bmc_pkg::SY_TUNDER];

	// threshold codes to the DACs; registered so a config glitch never
	// reaches the analog side mid-cycle
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			thresh_q <= '0;
		end else begin
			thresh_q <= thresh_cfg_in;
		end
	end

	// dock debounce: any drop of the comparator restarts the count
	bmc_timer #(.W(bmc_pkg::DOCK_W)) u_dock_deb (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.run_in(dock_s),
		.limit_in(bmc_pkg::DOCK_W'(DOCK_DEB_CYC)),
		.done_out(dock_done)
	);

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			dock_present_q <= 1'b0;
		end else if (!dock_s) begin
			dock_present_q <= 1'b0;
		end else if (dock_done) begin
			dock_present_q <= 1'b1;
		end
	end

	// battery-low release timer runs only while the battery is above
	bmc_timer #(.W(bmc_pkg::REL_W)) u_low_rel (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.run_in(low_q && low_above_s),
		.limit_in(bmc_pkg::REL_W'(REL_TO_CYC)),
		.done_out(low_done)
	);

	assign low_rel = low_q && low_done;

	// not latched: any dip below the threshold reasserts at once; the pin
	// copy has its own flop so the output carries no inverter
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			low_q <= 1'b0;
			low_n_q <= 1'b1;
		end else if (!low_above_s) begin
			low_q <= 1'b1;
			low_n_q <= 1'b0;
		end else if (low_rel) begin
			low_q <= 1'b0;
			low_n_q <= 1'b1;
		end
	end

	// clear events only count once the battery is back above the level
	assign clear_evt = low_rel | dock_present_q | pf_clear_cmd_in;

	bmc_timer #(.W(bmc_pkg::REL_W)) u_pf_rel (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.run_in(pf_pend_q && pf_above_s),
		.limit_in(bmc_pkg::REL_W'(REL_TO_CYC)),
		.done_out(pf_done)
	);

	// power-fail latch; falling below the level beats any release
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			pf_q <= 1'b0;
			pf_pend_q <= 1'b0;
		end else if (!pf_above_s) begin
			pf_q <= 1'b1;
			pf_pend_q <= 1'b0;
		end else if (pf_q && pf_pend_q && pf_done) begin
			pf_q <= 1'b0;
			pf_pend_q <= 1'b0;
		end else if (pf_q && clear_evt) begin
			pf_pend_q <= 1'b1;
		end
	end

	// programmed response on a fresh assertion of either indicator
	assign fault_rise = (!pf_above_s && !pf_q) || (!low_above_s && !low_q);

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			power_off_q <= 1'b0;
			force_q <= 1'b0;
		end else begin
			power_off_q <= fault_rise &&
				(fault_resp_in == bmc_pkg::BMC_RESP_POWER_OFF);
			// one pulse kills every channel, no sequence walk
			force_q <= fault_rise &&
				(fault_resp_in == bmc_pkg::BMC_RESP_FORCE);
		end
	end

	// hold outputs off; a new fault in the release cycle keeps the hold
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			held_q <= 1'b0;
		end else if (fault_rise && latch_off_en_in &&
			fault_resp_in != bmc_pkg::BMC_RESP_NONE) begin
			held_q <= 1'b1;
		end else if (pwr_toggle || power_on_cmd_in) begin
			held_q <= 1'b0;
		end
	end

	// margin write check: seven levels only on 4 and 5 in that mode
	always_comb begin
		wr_ok = 1'b0;
		if (margin_wr_in.valid) begin
			if (seven_level_en_in &&
				bmc_pkg::SEVEN_CH_MASK[margin_wr_in.ch]) begin
				wr_ok = margin_wr_in.level <= bmc_pkg::SEVEN_MAX;
			end else if (seven_level_en_in &&
				bmc_pkg::SEVEN_LOST_MASK[margin_wr_in.ch]) begin
				wr_ok = 1'b0;
			end else begin
				wr_ok = margin_wr_in.level <= bmc_pkg::MARGIN_LOW;
			end
		end
	end

	assign mask_set = wr_ok && uvov_suppress_en_in &&
		(margin_q[margin_wr_in.ch] != margin_wr_in.level);

	// margin state is volatile: reset always returns every channel nominal
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			margin_q <= '0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (seven_level_en_in && bmc_pkg::SEVEN_LOST_MASK[i]) begin
					margin_q[i] <= bmc_pkg::MARGIN_NOM;
				end else if (!seven_level_en_in &&
					margin_q[i] > bmc_pkg::MARGIN_LOW) begin
					margin_q[i] <= bmc_pkg::MARGIN_NOM;
				end else if (wr_ok && margin_wr_in.ch == 3'(i)) begin
					margin_q[i] <= margin_wr_in.level;
				end
			end
		end
	end

	// one shared settle window, restarted by each new move
	bmc_timer #(.W(bmc_pkg::SETTLE_W)) u_settle (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.run_in((|mask_q) && !mask_set),
		.limit_in(bmc_pkg::SETTLE_W'(bmc_pkg::SETTLE_CYC)),
		.done_out(settle_done)
	);

	// a fresh move beats the end of the window so it never goes unmasked
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			mask_q <= '0;
			busy_q <= 1'b0;
		end else begin
			if (mask_set) begin
				mask_q[margin_wr_in.ch] <= 1'b1;
			end else if (settle_done) begin
				mask_q <= '0;
			end
			// busy tells the host to keep off the configuration
			busy_q <= mask_set || ((|mask_q) && !settle_done);
		end
	end

	// charge termination limits from the selection codes
	always_comb begin
		unique case (chg_cfg_in.pre_tmr_sel)
			2'h1: pre_lim = bmc_pkg::PRE_TMR_MIN1;
			2'h2: pre_lim = bmc_pkg::PRE_TMR_MIN2;
			2'h3: pre_lim = bmc_pkg::PRE_TMR_MIN3;
			2'h0: pre_lim = '0;
		endcase
		unique case (chg_cfg_in.fast_tmr_sel)
			2'h1: fast_lim = bmc_pkg::FAST_TMR_MIN1;
			2'h2: fast_lim = bmc_pkg::FAST_TMR_MIN2;
			2'h3: fast_lim = bmc_pkg::FAST_TMR_MIN3;
			2'h0: fast_lim = '0;
		endcase
	end

	// timers keep running through a temperature suspension
	assign pre_run = state_q == bmc_pkg::BMC_CHG_PRE ||
		(state_q == bmc_pkg::BMC_CHG_SUSP && resume_q == bmc_pkg::BMC_CHG_PRE);
	assign fast_run = state_q == bmc_pkg::BMC_CHG_FAST ||
		state_q == bmc_pkg::BMC_CHG_TAPER ||
		(state_q == bmc_pkg::BMC_CHG_SUSP &&
		(resume_q == bmc_pkg::BMC_CHG_FAST ||
		resume_q == bmc_pkg::BMC_CHG_TAPER));
	assign tick = presc_q == bmc_pkg::PRESC_W'(MINUTE_CYC - 1);
	assign pre_exp = chg_cfg_in.pre_tmr_sel != 2'h0 && pre_min_q >= pre_lim;
	assign fast_exp = chg_cfg_in.fast_tmr_sel != 2'h0 &&
		fast_min_q >= fast_lim;

	// minute prescaler and the two minute counters
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in || !(pre_run || fast_run) || tick) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in || !pre_run) begin
			pre_min_q <= '0;
		end else if (tick && !pre_exp) begin
			pre_min_q <= pre_min_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in || !fast_run) begin
			fast_min_q <= '0;
		end else if (tick && !fast_exp) begin
			fast_min_q <= fast_min_q + 1'b1;
		end
	end

	// start command waits in a latch; dropped when the dock goes away
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			start_pend_q <= 1'b0;
		end else if (charge_start_cmd_in) begin
			start_pend_q <= 1'b1;
		end else if (!dock_present_q ||
			state_q != bmc_pkg::BMC_CHG_IDLE) begin
			start_pend_q <= 1'b0;
		end
	end

	assign chg_go = dock_present_q &&
		(!chg_cfg_in.wait_cmd || start_pend_q);

	// charger sequence; dock loss wins, then timer expiry, then temperature
	always_comb begin
		state_d = state_q;
		if (!dock_present_q) begin
			state_d = bmc_pkg::BMC_CHG_IDLE;
		end else if ((pre_run && pre_exp) || (fast_run && fast_exp)) begin
			state_d = bmc_pkg::BMC_CHG_DONE;
		end else begin
			unique case (state_q)
				bmc_pkg::BMC_CHG_IDLE: begin
					if (chg_go && !temp_bad) begin
						state_d = sync2_q[bmc_pkg::SY_V2] ?
							bmc_pkg::BMC_CHG_PRE : bmc_pkg::BMC_CHG_TRICKLE;
					end
				end
				bmc_pkg::BMC_CHG_TRICKLE: begin
					if (sync2_q[bmc_pkg::SY_V2]) begin
						state_d = bmc_pkg::BMC_CHG_PRE;
					end
				end
				bmc_pkg::BMC_CHG_PRE: begin
					if (sync2_q[bmc_pkg::SY_PREV]) begin
						state_d = bmc_pkg::BMC_CHG_FAST;
					end
				end
				bmc_pkg::BMC_CHG_FAST: begin
					if (sync2_q[bmc_pkg::SY_FLOAT]) begin
						state_d = chg_cfg_in.skip_taper ?
							bmc_pkg::BMC_CHG_DONE : bmc_pkg::BMC_CHG_TAPER;
					end
				end
				bmc_pkg::BMC_CHG_TAPER: begin
					if (sync2_q[bmc_pkg::SY_TERM]) begin
						state_d = bmc_pkg::BMC_CHG_DONE;
					end
				end
				bmc_pkg::BMC_CHG_SUSP: begin
					if (!temp_bad) begin
						state_d = resume_q;
					end
				end
				bmc_pkg::BMC_CHG_DONE: state_d = bmc_pkg::BMC_CHG_DONE;
				default: state_d = bmc_pkg::BMC_CHG_IDLE;
			endcase
			if (temp_bad && state_q != bmc_pkg::BMC_CHG_IDLE &&
				state_q != bmc_pkg::BMC_CHG_SUSP &&
				state_q != bmc_pkg::BMC_CHG_DONE) begin
				state_d = bmc_pkg::BMC_CHG_SUSP;
			end
		end
	end

	// state, resume point and the drive handed to the charge regulator
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			state_q <= bmc_pkg::BMC_CHG_IDLE;
			resume_q <= bmc_pkg::BMC_CHG_IDLE;
			charge_en_q <= 1'b0;
			current_q <= '0;
		end else begin
			state_q <= state_d;
			if (state_d == bmc_pkg::BMC_CHG_SUSP &&
				state_q != bmc_pkg::BMC_CHG_SUSP) begin
				resume_q <= state_q;
			end
			charge_en_q <= state_d == bmc_pkg::BMC_CHG_TRICKLE ||
				state_d == bmc_pkg::BMC_CHG_PRE ||
				state_d == bmc_pkg::BMC_CHG_FAST ||
				state_d == bmc_pkg::BMC_CHG_TAPER;
			// trickle uses the fixed 2 mA source, so its code stays zero
			if (state_d == bmc_pkg::BMC_CHG_PRE) begin
				current_q <= chg_cfg_in.pre_i_sel;
			end else if (state_d == bmc_pkg::BMC_CHG_FAST ||
				state_d == bmc_pkg::BMC_CHG_TAPER) begin
				current_q <= chg_cfg_in.fast_i_sel;
			end else begin
				current_q <= '0;
			end
		end
	end

	// fault log; an expiry in the clear cycle is kept
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			fault_q <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (i == bmc_pkg::FLT_PRE && pre_run && pre_exp &&
					dock_present_q) begin
					fault_q[i] <= 1'b1;
				end else if (i == bmc_pkg::FLT_FAST && fast_run && fast_exp &&
					dock_present_q) begin
					fault_q[i] <= 1'b1;
				end else if (fault_log_clear_in) begin
					fault_q[i] <= 1'b0;
				end
			end
		end
	end

	assign dock_present_out = dock_present_q;
	assign power_fail_out = pf_q;
	assign battery_low_n_out = low_n_q; // straight from its own flop
	assign power_off_req_out = power_off_q;
	assign force_shutdown_out = force_q;
	assign outputs_held_out = held_q;
	assign thresh_dac_out = thresh_q;
	assign margin_status_out = margin_q;
	assign uvov_mask_out = mask_q;
	assign dvm_busy_out = busy_q;
	assign charge_state_out = state_q;
	assign charge_en_out = charge_en_q;
	assign charge_current_out = current_q;
	assign charge_fault_out = fault_q;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	a_dock_debounce: assert property ($rose(dock_present_q) |->
		$past(dock_s, 1) && $past(dock_s, 8))
		else $error("dock present without steady input");
	a_pf_hold: assert property (pf_q && !pf_above_s |=> pf_q)
		else $error("power-fail released while battery low");
	a_pf_release: assert property ($fell(pf_q) |->
		$past(pf_pend_q) && $past(pf_above_s))
		else $error("power-fail released without clear and timeout");
	a_low_assert: assert property (!low_above_s |=> low_q)
		else $error("battery-low not asserted below threshold");
	// the timeout is never shorter than 8 cycles, so 8 steady cycles must
	// have passed above the threshold before any release
	a_low_release: assert property ($fell(low_q) |->
		$past(low_above_s) && $past(low_above_s, 8) && $past(low_q, 8))
		else $error("battery-low released early");
	// a second indicator one cycle later may legally pulse again
	a_fault_force: assert property (fault_rise &&
		fault_resp_in == bmc_pkg::BMC_RESP_FORCE |=>
		force_q ##1 (!force_q || $past(fault_rise)))
		else $error("force response missing");
	a_seven_lost: assert property (seven_level_en_in |=>
		margin_q[0] == bmc_pkg::MARGIN_NOM)
		else $error("lost channel kept a margin setting");
	a_temp_suspend: assert property (temp_bad && dock_present_q &&
		!pre_exp && !fast_exp && (state_q == bmc_pkg::BMC_CHG_FAST ||
		state_q == bmc_pkg::BMC_CHG_PRE) |=>
		state_q == bmc_pkg::BMC_CHG_SUSP)
		else $error("charging not suspended on temperature");
	a_timer_stop: assert property (pre_run && pre_exp &&
		dock_present_q |=> state_q == bmc_pkg::BMC_CHG_DONE && fault_q[0])
		else $error("pre-charge timer expiry not handled");

endmodule // bmc_ctrl

// ---- bench/bmc_batt.sv ----
// Purpose: cell and thermistor model; mV and degrees into comparator levels
// Assumes: levels follow the threshold codes the block drives
// Notes:   float voltage fixed at 4200 mV
`timescale 1ns/1ps
module bmc_batt (
	input bmc_pkg::bmc_thresh_t thr_in,
	input int mv_in,
	input int deg_in,
	output logic pf_above_out,
	output logic low_above_out,
	output logic above_2v_out,
	output logic above_pre_out,
	output logic at_float_out,
	output logic over_t_out,
	output logic under_t_out
);
	// pf, low and pre-charge comparators follow the dac codes, so a wrong code moves the trip; 2 V and float are fixed
	assign pf_above_out = mv_in > 2550 + 150 * int'(thr_in.pf_sel);
	assign low_above_out = mv_in > 2550 + 150 * int'(thr_in.low_sel);
	assign above_2v_out = mv_in > 2000;
	assign above_pre_out = mv_in > 2500 + 100 * int'(thr_in.pre_v_sel);
	assign at_float_out = mv_in >= 4200;
	// temperature trips follow the limit codes as well
	assign over_t_out = deg_in > 30 + 5 * int'(thr_in.over_t_sel);
	assign under_t_out = deg_in < -20 + 5 * int'(thr_in.under_t_sel);
endmodule // bmc_batt

// ---- bench/test_bmc_ctrl.sv ----
// Purpose: self-checking bench of the battery monitor and charger block
// Assumes: short counts through the block's parameters
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
	$display("mismatch %0t %0h %0h", $time, a, b); end end
module test_bmc_ctrl;
	logic clk = 1'b0, rst_b = 1'b0, dock = 1'b0, term = 1'b0, pin = 1'b0;
	logic clr = 1'b0, pon = 1'b0, lat = 1'b0, sev = 1'b0, sup = 1'b0;
	logic pfa, lowa, a2v, apre, flt, dp, pf, bl_n, poff, fsd, held, busy, cen;
	logic [23:0] ms;
	logic [7:0] mask;
	logic [3:0] cur;
	logic [1:0] cf;
	logic go = 1'b0, tov, tun;
	int mv = 3600, deg = 25, n_fail = 0, check_count = 0;
	bmc_pkg::bmc_margin_wr_t mw = 7'h00;
	bmc_pkg::bmc_thresh_t thr = 18'h023c0; // pf 2850, low 2700, pre 3200
	bmc_pkg::bmc_thresh_t dac;
	bmc_pkg::bmc_chg_cfg_t cfg = 14'h0e40;
	bmc_pkg::bmc_resp_t resp = bmc_pkg::BMC_RESP_NONE;
	bmc_pkg::bmc_chg_state_t st;
	// short counts keep the run brief; expectations use the same figures
	bmc_ctrl #(.DOCK_DEB_CYC(20), .REL_TO_CYC(10), .MINUTE_CYC(4)) dut_u (
		.ref_clk_in(clk), .rst_b_in(rst_b), .dock_above_in(dock),
		.pf_above_in(pfa), .low_above_in(lowa), .batt_above_2v_in(a2v),
		.batt_above_pre_in(apre), .batt_at_float_in(flt),
		.chg_below_term_in(term), .temp_over_in(tov), .temp_under_in(tun),
		.power_on_pin_in(pin), .pf_clear_cmd_in(clr), .power_on_cmd_in(pon),
		.charge_start_cmd_in(go), .fault_log_clear_in(1'b0),
		.margin_wr_in(mw), .thresh_cfg_in(thr), .chg_cfg_in(cfg),
		.fault_resp_in(resp), .latch_off_en_in(lat), .seven_level_en_in(sev),
		.uvov_suppress_en_in(sup), .dock_present_out(dp),
		.power_fail_out(pf), .battery_low_n_out(bl_n),
		.power_off_req_out(poff), .force_shutdown_out(fsd),
		.outputs_held_out(held), .thresh_dac_out(dac),
		.margin_status_out(ms), .uvov_mask_out(mask), .dvm_busy_out(busy),
		.charge_state_out(st), .charge_en_out(cen),
		.charge_current_out(cur), .charge_fault_out(cf));
	bmc_batt batt_u (.thr_in(dac), .mv_in(mv), .pf_above_out(pfa),
		.low_above_out(lowa), .above_2v_out(a2v), .above_pre_out(apre),
		.at_float_out(flt), .deg_in(deg), .over_t_out(tov),
		.under_t_out(tun));
	// free-running 25 MHz clock
	always #20 clk = ~clk;
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask
	task automatic end_of_test;
		if (n_fail == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// deep drop hits both levels; low release clears the latch; pin toggle
	// ends the hold
	task automatic t_low;
		resp = bmc_pkg::BMC_RESP_FORCE;
		lat = 1'b1;
		mv = 2600;
		step(3);
		`CHK({bl_n, fsd, pf, held}, 4'h7)
		step(1);
		`CHK(fsd, 1'b0)
		mv = 3600;
		step(8);
		`CHK(bl_n, 1'b0)
		step(8);
		`CHK({bl_n, pf}, 2'h3)
		step(16);
		`CHK(pf, 1'b0)
		pin = 1'b1;
		step(4);
		`CHK(held, 1'b0)
	endtask
	// clear refused while below level, then taken; hold until power-on
	task automatic t_pf;
		resp = bmc_pkg::BMC_RESP_POWER_OFF;
		lat = 1'b1;
		mv = 2800;
		step(3);
		`CHK({pf, poff, held, bl_n}, 4'hf)
		step(1);
		`CHK(poff, 1'b0)
		pulse(clr);
		mv = 3600;
		step(20);
		`CHK(pf, 1'b1)
		pulse(clr);
		step(8);
		`CHK(pf, 1'b1)
		step(6);
		`CHK({pf, held}, 2'h1)
		pulse(pon);
		`CHK(held, 1'b0)
	endtask
	// normal write, seven-level write, refused channel, settle mask, exit
	task automatic t_margin;
		sup = 1'b1;
		mw = {1'b1, 3'h0, 3'h1};
		step(1);
		mw = {1'b1, 3'h4, 3'h5};
		sev = 1'b1;
		`CHK(ms[2:0], 3'h1)
		step(1);
		mw = {1'b1, 3'h0, 3'h1};
		`CHK({ms[14:12], ms[2:0], mask[4], busy}, 8'ha3)
		step(1);
		mw = 7'h00;
		`CHK(ms[2:0], 3'h0)
		step(1240);
		`CHK({mask[4], busy}, 2'h3)
		step(20);
		`CHK({mask, busy}, 9'h000)
		sev = 1'b0;
		mw = {1'b1, 3'h7, 3'h2};
		step(1);
		mw = 7'h00;
		step(1);
		`CHK({ms[23:21], ms[14:12]}, 6'h10)
		// no configuration change until the voltage move has settled
		step(1255);
		`CHK(busy, 1'b0)
	endtask
	// debounce, then pre, fast, taper and done; dock loss returns to idle
	task automatic t_charge;
		mv = 3000;
		dock = 1'b1;
		step(21);
		`CHK(dp, 1'b0)
		step(4);
		`CHK(dp, 1'b1)
		step(4);
		`CHK({st, cur}, {bmc_pkg::BMC_CHG_PRE, 4'h3})
		mv = 3600;
		step(4);
		`CHK({st, cur}, {bmc_pkg::BMC_CHG_FAST, 4'h9})
		deg = 70;
		step(4);
		`CHK({st, cen}, {bmc_pkg::BMC_CHG_SUSP, 1'b0})
		deg = -30;
		step(4);
		`CHK(st, bmc_pkg::BMC_CHG_SUSP)
		deg = 25;
		step(4);
		`CHK({st, cen}, {bmc_pkg::BMC_CHG_FAST, 1'b1})
		mv = 4300;
		step(4);
		`CHK(st, bmc_pkg::BMC_CHG_TAPER)
		term = 1'b1;
		step(4);
		`CHK({st, cen}, {bmc_pkg::BMC_CHG_DONE, 1'b0})
		dock = 1'b0;
		term = 1'b0;
		step(4);
		`CHK(st, bmc_pkg::BMC_CHG_IDLE)
	endtask
	// start waits for the command; 44 minute pre timer at 4 cycles a minute
	task automatic t_timer;
		cfg = 14'h0e64;
		mv = 3000;
		dock = 1'b1;
		step(30);
		`CHK({dp, st}, {1'b1, bmc_pkg::BMC_CHG_IDLE})
		pulse(go);
		step(100);
		`CHK(st, bmc_pkg::BMC_CHG_PRE)
		step(130);
		`CHK({st, cf, cen}, {bmc_pkg::BMC_CHG_DONE, 3'h2})
	endtask
	// reset for 12 cycles, then the scenarios in turn
	initial begin
		step(12);
		rst_b = 1'b1;
		step(2);
		t_low();
		t_pf();
		t_margin();
		t_charge();
		t_timer();
		end_of_test();
	end
	// the tests need about 3000 cycles; a hang is cut short well after
	initial begin
		#400_000;
		n_fail++;
		end_of_test();
	end
endmodule // test_bmc_ctrl
